// *** adc_regs_pkg.sv ***
// Shared constants, field layouts and types for the converter status and calibration access block.
package adc_regs_pkg;

   // Read-source codes held in the control word.
   typedef enum logic [1:0] {
      RS_RESULT = 2'b00,
      RS_CAL_WRITE = 2'b01,
      RS_CAL_READ = 2'b10,
      RS_STATUS = 2'b11
   } read_source_t;

   // Control word layout, most significant field first.
   typedef struct packed {
      logic [1:0] spare;
      logic single_ended_sel;
      logic [2:0] channel_sel;
      logic [1:0] power_mgmt;
      read_source_t read_source_sel;
      logic analog_range_mode;
      logic conv_start;
      logic calibration_kind;
      logic [1:0] cal_select;
      logic cal_start;
   } ctrl_t;

   localparam int WORD_W = 16;
   localparam int CAL_DATA_W = 14;
   localparam int RESULT_W = 12;
   localparam int PIN_W = 21;

   localparam ctrl_t CTRL_RESET = ctrl_t'(16'h0000);
   localparam logic [15:0] STATUS_RESET = 16'h0000;

   // Status word constant bits.
   localparam logic [1:0] STATUS_TOP_ZEROS = 2'b00;
   localparam logic [1:0] STATUS_MID_ONES = 2'b11;

   // Calibration register indices in access order.
   localparam int CAL_REG_COUNT = 10;
   localparam logic [3:0] CAL_IDX_GAIN = 4'h0;
   localparam logic [3:0] CAL_IDX_OFFSET = 4'h1;
   localparam logic [3:0] CAL_IDX_DAC_FIRST = 4'h2;
   localparam logic [3:0] CAL_IDX_DAC_LAST = 4'h9;

   // Calibration select codes.
   localparam logic [1:0] CALSEL_ALL = 2'b00;
   localparam logic [1:0] CALSEL_GAIN_OFFSET = 2'b01;
   localparam logic [1:0] CALSEL_OFFSET = 2'b10;
   localparam logic [1:0] CALSEL_GAIN = 2'b11;

   // Calibration register contents after reset.
   localparam logic [13:0] CAL_GAIN_RESET = 14'h2000;
   localparam logic [13:0] CAL_OFFSET_RESET = 14'h2000;
   localparam logic [13:0] CAL_DAC_RESET = 14'h0000;

   // Pin bit positions in the synchronised pin vector.
   localparam int PIN_CS_N = 20;
   localparam int PIN_RD_N = 19;
   localparam int PIN_WR_N = 18;
   localparam int PIN_HBE = 17;
   localparam int PIN_BYTE = 16;

endpackage : adc_regs_pkg

// *** pin_sync.sv ***
// Two-stage synchroniser for asynchronous pins, with a third stage for edge detection.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 21,
   parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o,
   output logic [WIDTH-1:0] q_prev_o
);

   logic [WIDTH-1:0] meta_r;

   // Only the second stage reads the first, so a metastable sample never reaches logic.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= RESET_VAL;
         q_o <= RESET_VAL;
         q_prev_o <= RESET_VAL;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
         q_prev_o <= q_o;
      end
   end

endmodule : pin_sync

// *** adc_status_cal_access.sv ***
// Host parallel-bus access to the control word, status word and calibration registers.
`timescale 1ns/1ps
module adc_status_cal_access
   import adc_regs_pkg::*;
(
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CS_N_I,
   input wire logic RD_N_I,
   input wire logic WR_N_I,
   input wire logic HIGH_BYTE_ENABLE_I,
   input wire logic BYTE_MODE_I,
   input wire logic [15:0] DB_I,
   output logic [15:0] DB_O,
   output logic DB_OE_N_O,
   input wire logic CONV_BUSY_I,
   input wire logic CAL_BUSY_I,
   input wire logic [11:0] RESULT_I,
   input wire logic CAL_UPD_I,
   input wire logic [3:0] CAL_UPD_IDX_I,
   input wire logic [13:0] CAL_UPD_DATA_I,
   output ctrl_t CTRL_O,
   output logic CONV_START_O,
   output logic CAL_START_O,
   output logic [15:0] GAIN_WORD_O,
   output logic [15:0] OFFSET_WORD_O
);

   // First register of the access sequence for a select code.
   function automatic logic [3:0] cal_first_idx(input logic [1:0] sel);
      cal_first_idx = (sel == CALSEL_OFFSET) ? CAL_IDX_OFFSET : CAL_IDX_GAIN;
   endfunction : cal_first_idx

   // Last register of the access sequence for a select code.
   function automatic logic [3:0] cal_last_idx(input logic [1:0] sel);
      case (sel)
         CALSEL_ALL: cal_last_idx = CAL_IDX_DAC_LAST;
         CALSEL_GAIN_OFFSET: cal_last_idx = CAL_IDX_OFFSET;
         CALSEL_OFFSET: cal_last_idx = CAL_IDX_OFFSET;
         default: cal_last_idx = CAL_IDX_GAIN;
      endcase
   endfunction : cal_last_idx

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s;
   logic [PIN_W-1:0] pin_p;

   logic rd_act;
   logic rd_prev;
   logic wr_act;
   logic wr_prev;
   logic rd_start;
   logic rd_end;
   logic wr_end;
   logic byte_mode;
   logic hbe_now;
   logic hbe_prev;
   logic [15:0] bus_prev;

   ctrl_t ctrl_r;
   ctrl_t ctrl_nxt;
   logic power_up_r;
   logic [7:0] lo_byte_r;
   logic [3:0] ptr_r;
   logic [13:0] cal_mem [0:CAL_REG_COUNT-1];
   logic [15:0] dout_r;
   logic oe_n_r;
   logic conv_start_r;
   logic cal_start_r;

   logic [15:0] wr_word;
   ctrl_t wr_ctrl;
   logic word_done;
   logic cal_wr_mode;
   logic ctrl_wr;
   logic cal_host_wr;
   logic rd_done;
   logic cal_rd_adv;
   logic ptr_adv;
   logic seq_done;
   logic [15:0] status_word;
   logic [15:0] read_word;

   assign pin_raw = {CS_N_I, RD_N_I, WR_N_I, HIGH_BYTE_ENABLE_I, BYTE_MODE_I, DB_I};

   pin_sync #(
      .WIDTH(PIN_W),
      .RESET_VAL({5'h1f, 16'h0000})
   ) u_pin_sync (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .d_i(pin_raw),
      .q_o(pin_s),
      .q_prev_o(pin_p)
   );

   // Strobe decode on the synchronised pins; the previous sample still holds the bus data
   // of the access that is ending, so a write is captured from it on the trailing edge.
   assign rd_act = ~pin_s[PIN_CS_N] & ~pin_s[PIN_RD_N];
   assign rd_prev = ~pin_p[PIN_CS_N] & ~pin_p[PIN_RD_N];
   assign wr_act = ~pin_s[PIN_CS_N] & ~pin_s[PIN_WR_N];
   assign wr_prev = ~pin_p[PIN_CS_N] & ~pin_p[PIN_WR_N];
   assign rd_start = rd_act & ~rd_prev;
   assign rd_end = ~rd_act & rd_prev;
   assign wr_end = ~wr_act & wr_prev;
   assign byte_mode = pin_s[PIN_BYTE];
   assign hbe_now = pin_s[PIN_HBE];
   assign hbe_prev = pin_p[PIN_HBE];
   assign bus_prev = pin_p[15:0];

   // Byte mode assembles the word from a low byte then a high byte.
   assign wr_word = byte_mode ? {bus_prev[7:0], lo_byte_r} : bus_prev;
   assign wr_ctrl = ctrl_t'(wr_word);
   assign word_done = wr_end & (~byte_mode | hbe_prev);

   assign cal_wr_mode = (ctrl_r.read_source_sel == RS_CAL_WRITE);
   assign ctrl_wr = word_done & ~cal_wr_mode;
   assign cal_host_wr = word_done & cal_wr_mode;
   assign rd_done = rd_end & (~byte_mode | hbe_prev);
   assign cal_rd_adv = rd_done & (ctrl_r.read_source_sel == RS_CAL_READ);
   assign ptr_adv = cal_host_wr | cal_rd_adv;
   assign seq_done = ptr_adv & (ptr_r == cal_last_idx(ctrl_r.cal_select));

   // The start bits act as pulses and are not kept in the stored control word.
   always_comb begin
      ctrl_nxt = wr_ctrl;
      ctrl_nxt.spare = 2'b00;
      ctrl_nxt.conv_start = 1'b0;
      ctrl_nxt.cal_start = 1'b0;
   end

   // Control word, written by a host write outside calibration write access; the end of a calibration write set clears its read source.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         ctrl_r <= CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_r <= ctrl_nxt;
      end else if (seq_done && cal_wr_mode) begin
         // Leaving write access at the end of the set lets the next write reach control.
         ctrl_r.read_source_sel <= RS_RESULT;
      end
   end

   // Status reads zero until the host first writes the control word.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         power_up_r <= 1'b1;
      end else if (ctrl_wr) begin
         power_up_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         lo_byte_r <= 8'h00;
      end else if (wr_end && byte_mode && !hbe_prev) begin
         lo_byte_r <= bus_prev[7:0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         conv_start_r <= 1'b0;
         cal_start_r <= 1'b0;
      end else begin
         conv_start_r <= ctrl_wr & wr_ctrl.conv_start;
         cal_start_r <= ctrl_wr & wr_ctrl.cal_start;
      end
   end

   // Calibration register pointer.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         ptr_r <= CAL_IDX_GAIN;
      end else if (ctrl_wr) begin
         ptr_r <= cal_first_idx(ctrl_nxt.cal_select);
      end else if (seq_done) begin
         ptr_r <= cal_first_idx(ctrl_r.cal_select);
      end else if (ptr_adv) begin
         ptr_r <= ptr_r + 4'h1;
      end
   end

   // Calibration storage. The engine wins over a host write in the same cycle, since a
   // running calibration owns the coefficients and the host is told not to access them.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         for (int i = 0; i < CAL_REG_COUNT; i++) begin
            cal_mem[i] <= CAL_DAC_RESET;
         end
         cal_mem[CAL_IDX_GAIN] <= CAL_GAIN_RESET;
         cal_mem[CAL_IDX_OFFSET] <= CAL_OFFSET_RESET;
      end else if (CAL_UPD_I && (CAL_UPD_IDX_I <= CAL_IDX_DAC_LAST)) begin
         cal_mem[CAL_UPD_IDX_I] <= CAL_UPD_DATA_I;
      end else if (cal_host_wr) begin
         cal_mem[ptr_r] <= wr_word[CAL_DATA_W-1:0];
      end
   end

   // Status word assembly; host writes reach it through the control word fields that it mirrors and, on the first control write, by ending the power-up zero.
   always_comb begin
      if (power_up_r) begin
         status_word = STATUS_RESET;
      end else begin
         status_word = {STATUS_TOP_ZEROS,
                        ctrl_r.single_ended_sel,
                        ctrl_r.channel_sel,
                        ctrl_r.power_mgmt,
                        STATUS_MID_ONES,
                        ctrl_r.analog_range_mode,
                        CONV_BUSY_I | CAL_BUSY_I,
                        ctrl_r.calibration_kind,
                        ctrl_r.cal_select,
                        CAL_BUSY_I};
      end
   end

   // Read source multiplexer.
   always_comb begin
      case (ctrl_r.read_source_sel)
         RS_RESULT: read_word = {4'h0, RESULT_I};
         RS_CAL_READ: read_word = {2'b00, cal_mem[ptr_r]};
         RS_STATUS: read_word = status_word;
         default: read_word = 16'h0000;
      endcase
   end

   // Read data is captured at the start of the strobe and held steady while it lasts.
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         dout_r <= 16'h0000;
      end else if (rd_start) begin
         if (byte_mode) begin
            dout_r <= hbe_now ? {8'h00, read_word[15:8]} : {8'h00, read_word[7:0]};
         end else begin
            dout_r <= read_word;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         oe_n_r <= 1'b1;
      end else begin
         oe_n_r <= ~rd_act;
      end
   end

   assign DB_O = dout_r;
   assign DB_OE_N_O = oe_n_r;
   assign CTRL_O = ctrl_r;
   assign CONV_START_O = conv_start_r;
   assign CAL_START_O = cal_start_r;
   assign GAIN_WORD_O = {2'b00, cal_mem[CAL_IDX_GAIN]};
   assign OFFSET_WORD_O = {2'b00, cal_mem[CAL_IDX_OFFSET]};

endmodule : adc_status_cal_access

// *** host_bus_model.sv ***
// Host processor model driving the parallel bus strobes and data pins.
`timescale 1ns/1ps
module host_bus_model (
   input wire logic clk_i,
   input wire logic byte_i,
   input wire logic [15:0] rd_data_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic hbe_o,
   output logic [15:0] db_o
);
   initial begin
      {cs_n_o, rd_n_o, wr_n_o, hbe_o} = 4'he;
      db_o = 16'h0000;
   end
   // Strobes stay low four cycles and high six between transfers, so both clear the three-cycle minimum.
   task automatic cyc(input logic rd, input logic hbe, input logic [15:0] d,
                      output logic [15:0] q);
      @(posedge clk_i);
      #1;
      {cs_n_o, rd_n_o, wr_n_o, hbe_o} = {1'b0, !rd, rd, hbe};
      db_o = d;
      repeat (4) @(posedge clk_i);
      q = rd_data_i;
      #1;
      {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
      repeat (2) @(posedge clk_i);
      #1;
      // Nobody holds the bus after release, so stale data must not look valid.
      db_o = ~d;
      repeat (3) @(posedge clk_i);
   endtask : cyc
   task automatic xfer(input logic rd, input logic [15:0] d, output logic [15:0] q);
      logic [15:0] lo;
      if (byte_i) begin
         cyc(rd, 1'b0, {~d[15:8], d[7:0]}, lo);
         cyc(rd, 1'b1, {~d[7:0], d[15:8]}, q);
         q = {q[7:0], lo[7:0]};
      end else begin
         cyc(rd, 1'b0, d, q);
      end
   endtask : xfer
endmodule : host_bus_model

// *** adc_status_cal_access_properties.sv ***
// Concurrent checks on the ports of the status and calibration access block.
`timescale 1ns/1ps
module adc_status_cal_access_properties
   import adc_regs_pkg::*;
(
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CS_N_I,
   input wire logic RD_N_I,
   input wire logic BYTE_MODE_I,
   input wire logic [15:0] DB_O,
   input wire logic DB_OE_N_O,
   input wire logic CAL_UPD_I,
   input wire logic [3:0] CAL_UPD_IDX_I,
   input wire logic [13:0] CAL_UPD_DATA_I,
   input wire ctrl_t CTRL_O,
   input wire logic [15:0] GAIN_WORD_O,
   input wire logic [15:0] OFFSET_WORD_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence s_rd(read_source_t rs);
      $fell(DB_OE_N_O) && !BYTE_MODE_I && CTRL_O.read_source_sel == rs;
   endsequence
   property p_upd(logic [3:0] idx, logic [15:0] word);
      CAL_UPD_I && CAL_UPD_IDX_I == idx |=> word == {2'b00, $past(CAL_UPD_DATA_I)};
   endproperty
   a_reset_state: assert property (disable iff (1'b0) $fell(SYS_RST_I) |->
      CTRL_O == CTRL_RESET && DB_OE_N_O) else $error("state after reset wrong");
   a_status_fixed: assert property (s_rd(RS_STATUS) |->
      DB_O[15:14] == STATUS_TOP_ZEROS && DB_O[7:6] == STATUS_MID_ONES)
      else $error("status constant bits wrong");
   a_status_fields: assert property (s_rd(RS_STATUS) |->
      DB_O[13:8] == {CTRL_O.single_ended_sel, CTRL_O.channel_sel, CTRL_O.power_mgmt}
      && DB_O[5] == CTRL_O.analog_range_mode
      && DB_O[3:1] == {CTRL_O.calibration_kind, CTRL_O.cal_select})
      else $error("status field mirror wrong");
   a_cal_lead_zero: assert property (s_rd(RS_CAL_READ) |-> DB_O[15:14] == 2'b00)
      else $error("calibration read lacks leading zeros");
   a_drive_on_read: assert property ($fell(DB_OE_N_O) |-> $past(!RD_N_I && !CS_N_I, 2))
      else $error("bus driven without a read");
   a_engine_gain: assert property (p_upd(CAL_IDX_GAIN, GAIN_WORD_O))
      else $error("engine gain update lost");
   a_engine_offset: assert property (p_upd(CAL_IDX_OFFSET, OFFSET_WORD_O))
      else $error("engine offset update lost");
   a_word_tops: assert property (GAIN_WORD_O[15:14] == 2'b00 && OFFSET_WORD_O[15:14] == 2'b00)
      else $error("calibration word top bits set");
endmodule : adc_status_cal_access_properties
bind adc_status_cal_access adc_status_cal_access_properties chk (
   .CLK_I(CLK_I),
   .SYS_RST_I(SYS_RST_I),
   .CS_N_I(CS_N_I),
   .RD_N_I(RD_N_I),
   .BYTE_MODE_I(BYTE_MODE_I),
   .DB_O(DB_O),
   .DB_OE_N_O(DB_OE_N_O),
   .CAL_UPD_I(CAL_UPD_I),
   .CAL_UPD_IDX_I(CAL_UPD_IDX_I),
   .CAL_UPD_DATA_I(CAL_UPD_DATA_I),
   .CTRL_O(CTRL_O),
   .GAIN_WORD_O(GAIN_WORD_O),
   .OFFSET_WORD_O(OFFSET_WORD_O)
);

// *** test_adc_status_cal_access.sv ***
// Self-checking bench for the status and calibration access block.
`timescale 1ns/1ps
module test_adc_status_cal_access;
   import adc_regs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic byte_m = 1'b0;
   logic conv_b = 1'b0;
   logic cal_b = 1'b0;
   logic upd = 1'b0;
   logic [3:0] upd_idx = 4'h0;
   logic [13:0] upd_data = 14'h0000;
   logic [11:0] res = 12'habc;
   logic conv_st;
   logic cal_st;
   logic [7:0] n_conv = 8'h00;
   logic [7:0] n_cal = 8'h00;
   logic cs_n, rd_n, wr_n, hbe, oe_n;
   logic [15:0] db_in, db_out, gain_w, offs_w;
   logic [15:0] w [10];
   ctrl_t ctrl;
   int n_errors = 0;
   int n_tests = 0;
   always #20 clk = ~clk;
   // Counting high cycles shows both that a start pulse came and that it lasted one cycle.
   always @(posedge clk) begin
      if (conv_st === 1'b1) n_conv <= n_conv + 8'h01;
      if (cal_st === 1'b1) n_cal <= n_cal + 8'h01;
   end
   host_bus_model host (.clk_i(clk), .byte_i(byte_m), .rd_data_i(db_out), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .hbe_o(hbe), .db_o(db_in));
   adc_status_cal_access uut (.CLK_I(clk), .SYS_RST_I(rst), .CS_N_I(cs_n), .RD_N_I(rd_n),
      .WR_N_I(wr_n), .HIGH_BYTE_ENABLE_I(hbe), .BYTE_MODE_I(byte_m), .DB_I(db_in),
      .DB_O(db_out), .DB_OE_N_O(oe_n), .CONV_BUSY_I(conv_b), .CAL_BUSY_I(cal_b),
      .RESULT_I(res), .CAL_UPD_I(upd), .CAL_UPD_IDX_I(upd_idx),
      .CAL_UPD_DATA_I(upd_data), .CTRL_O(ctrl), .CONV_START_O(conv_st), .CAL_START_O(cal_st),
      .GAIN_WORD_O(gain_w), .OFFSET_WORD_O(offs_w));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask : chk
   task automatic put(input logic [15:0] d);
      logic [15:0] q;
      host.xfer(1'b0, d, q);
   endtask : put
   task automatic rd(input string what, input logic [15:0] exp);
      logic [15:0] q;
      host.xfer(1'b1, 16'hffff, q);
      chk(what, exp, q);
   endtask : rd
   task automatic t_status();
      put(16'h3fee);
      rd("status", 16'h3fee);
      #1 conv_b = 1'b1;
      rd("status conv", 16'h3ffe);
      #1 {conv_b, cal_b} = 2'b01;
      rd("status cal", 16'h3fff);
      #1 cal_b = 1'b0;
      put(16'h00c0);
      rd("status plain", 16'h00c0);
      put(16'h00d1);
      rd("status starts", 16'h00c0);
      chk("start pulses", 16'h0101, {n_conv, n_cal});
   endtask : t_status
   task automatic t_cal_all();
      put(16'h0040);
      for (int i = 0; i < 10; i++) begin
         w[i] = 16'hc000 | 16'(i * 16'h0517);
         put(w[i]);
      end
      repeat (2) @(posedge clk);
      chk("gain word", w[0] & 16'h3fff, gain_w);
      chk("offset word", w[1] & 16'h3fff, offs_w);
      put(16'h0080);
      for (int i = 0; i < 10; i++) rd("cal read", w[i] & 16'h3fff);
      rd("cal wrap", w[0] & 16'h3fff);
      rd("cal next", w[1] & 16'h3fff);
      put(16'h0080);
      rd("cal abort", w[0] & 16'h3fff);
   endtask : t_cal_all
   task automatic t_cal_sets();
      put(16'h0042);
      put(16'h1111);
      put(16'h2222);
      put(16'h0082);
      rd("gain first", 16'h1111);
      rd("offset second", 16'h2222);
      put(16'h0044);
      put(16'h0333);
      repeat (2) @(posedge clk);
      chk("offset only", 16'h0333, offs_w);
      chk("gain kept", 16'h1111, gain_w);
      rd("result after set", 16'h0abc);
      put(16'h0084);
      rd("offset read", 16'h0333);
      put(16'h0086);
      rd("gain only", 16'h1111);
      rd("gain again", 16'h1111);
   endtask : t_cal_sets
   task automatic t_bytes();
      #1 byte_m = 1'b1;
      repeat (4) @(posedge clk);
      put(16'h0046);
      put(16'h1234);
      repeat (2) @(posedge clk);
      chk("byte gain", 16'h1234, gain_w);
      put(16'h0082);
      rd("byte gain read", 16'h1234);
      rd("byte offset read", 16'h0333);
      #1 byte_m = 1'b0;
      repeat (4) @(posedge clk);
   endtask : t_bytes
   task automatic t_engine();
      #1 {upd, upd_idx, upd_data} = {1'b1, CAL_IDX_OFFSET, 14'h2abc};
      @(posedge clk);
      #1 {upd_idx, upd_data} = {4'hf, 14'h0001};
      @(posedge clk);
      #1 upd = 1'b0;
      repeat (3) @(posedge clk);
      chk("engine offset", 16'h2abc, offs_w);
      chk("bad index ignored", 16'h1234, gain_w);
      #1 {upd, upd_idx, upd_data} = {1'b1, CAL_IDX_GAIN, 14'h1555};
      @(posedge clk);
      #1 upd = 1'b0;
      @(posedge clk);
      chk("engine gain", 16'h1555, gain_w);
   endtask : t_engine
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   initial begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      chk("control reset", 16'h0000, 16'(ctrl));
      chk("drive off", 16'h0001, {15'h0000, oe_n});
      t_status();
      t_cal_all();
      t_cal_sets();
      t_bytes();
      t_engine();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      close_out();
   end
endmodule : test_adc_status_cal_access
